// ===== logic/mbsh_handler.sv
// Request decoder, coil and holding register store and reply builder.
// Assumes an upstream framer that strips the CRC and flags it per frame,
// and a downstream framer that appends the CRC to the reply bytes.
//
// Overview of operation
// - Single-coil force sets one addressed coil; broadcast forces it too.
// - Coil addresses are zero-based; coil 65 travels as address 64.
// - Force value FF00 means ON, 0000 means OFF.
// - Single-coil force echoes the request after the coil has changed.
// - Coil 65 is the parameter write control setting.
// - Multiple-coil force sets every coil of the contiguous range below address 128.
// - Coils 17 to 32 hold the 16-bit speed setpoint.
// - Multiple-coil reply: address, function, start, count, no data.
// - Register read gives start and count; addresses are zero-based.
// - Read reply: byte count, then each register high byte first.
// - Single-register preset writes the 16-bit value to one register.
// - Single-register preset echoes the request after the write.
// - Multiple-register preset writes consecutive registers, high first.
// - Multiple-register reply: address, function, start, register count.
// - Write control 1 stores parameters in NVM and RAM, else RAM only.
// - Parameter register address on the bus is ten times its number.
`timescale 1ns/100ps
module mbsh_handler
  import mbsh_pkg::*;
#(
  parameter logic [7:0] SLAVE_ADDR = 8'h01
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Request bytes from the framer
  input wire mbsh_pkg::mbsh_rx_s rx_i,
  // Reply bytes to the framer
  output mbsh_pkg::mbsh_tx_s tx_o,
  input wire logic tx_ready_i,
  // Drive-side view
  output logic [15:0] speed_ref_o,
  output logic wrctl_o,
  output logic param_wr_o,
  output logic param_nvm_o,
  output logic [15:0] param_num_o,
  output logic [15:0] param_data_o,
  output logic busy_o
);
  import mbsh_pkg::*;

  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} mbsh_state_e;

  mbsh_state_e state_ff;
  logic [7:0] buf_ff [MAX_FRAME];
  logic [5:0] len_ff;
  logic [5:0] idx_ff;
  logic [5:0] tx_len_ff;
  logic [15:0] cnt_ff;
  logic [NUM_COILS-1:0] coil_ff;
  logic [15:0] reg_ff [NUM_REGS];
  logic param_wr_ff;
  logic [15:0] param_num_ff;
  logic [15:0] param_data_ff;

  function automatic logic [15:0] word_at(input logic [7:0] hi,
                                          input logic [7:0] lo);
    word_at = {hi, lo};
  endfunction

  // ==========================================================
  // Request decode
  wire logic [7:0] fc = buf_ff[1];
  wire logic bcast = (buf_ff[0] == BCAST_ADDR);
  wire logic for_us = (buf_ff[0] == SLAVE_ADDR) || bcast;
  wire logic [15:0] start = word_at(buf_ff[2], buf_ff[3]);
  wire logic [15:0] qty = word_at(buf_ff[4], buf_ff[5]);
  wire logic [15:0] offs = start + cnt_ff;
  wire logic is_write = (fc != FC_READ_HOLD);
  wire logic fc_ok = (fc == FC_READ_HOLD) || (fc == FC_FORCE_ONE) ||
                     (fc == FC_PRESET_ONE) || (fc == FC_FORCE_MANY) ||
                     (fc == FC_PRESET_MANY);
  wire logic val_ok = (fc != FC_FORCE_ONE) || (qty == COIL_ON) ||
                      (qty == COIL_OFF);
  wire logic frame_end = rx_i.valid && rx_i.last;
  wire logic take = frame_end && rx_i.crc_ok;
  wire logic [5:0] rlen = len_ff + 6'd1;
  // Reads longer than the frame buffer are dropped rather than letting
  // the 6-bit reply counter wrap.
  wire logic rd_fits = (fc != FC_READ_HOLD) ||
                       (qty <= 16'((MAX_FRAME - 3) / 2));
  // The minimum frame length leaves out the two CRC bytes.
  wire logic accept = for_us && fc_ok && val_ok && rd_fits &&
                      (len_ff >= 6'(REQ_MIN_LEN - 2));
  // Loop bound for the execution walk, one step per item.
  wire logic [15:0] steps = (fc == FC_FORCE_ONE || fc == FC_PRESET_ONE) ?
                            16'h0001 : qty;
  wire logic exec_done = (cnt_ff >= steps);
  wire logic [5:0] dbyte = 6'(7) + 6'(cnt_ff << 1);
  wire logic [5:0] cbyte = 6'(7) + 6'(cnt_ff >> 3);
  wire logic [2:0] cbit = cnt_ff[2:0];
  wire logic [15:0] preg = (fc == FC_PRESET_ONE) ? qty :
                           word_at(buf_ff[dbyte], buf_ff[dbyte + 6'd1]);
  wire logic creg = (fc == FC_FORCE_ONE) ? (qty == COIL_ON) :
                    buf_ff[cbyte][cbit];
  wire logic [5:0] rd_len = 6'(3) + 6'(qty << 1);

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_ff <= ST_RX;
      len_ff <= 6'd0;
      idx_ff <= 6'd0;
      tx_len_ff <= 6'd0;
      cnt_ff <= 16'h0000;
    end
    else
    begin
      case (state_ff)
        ST_RX:
        begin
          if (rx_i.valid)
            len_ff <= (len_ff < 6'(MAX_FRAME - 1)) ? rlen : len_ff;
          // A good frame keeps its length for the decode in ST_EXEC.
          if (frame_end && !rx_i.crc_ok)
            len_ff <= 6'd0;
          cnt_ff <= 16'h0000;
          if (take)
            state_ff <= ST_EXEC;
        end
        ST_EXEC:
        begin
          // Whole frame is checked here; a rejected one just vanishes.
          if (!accept)
          begin
            len_ff <= 6'd0;
            state_ff <= ST_RX;
          end
          else if (exec_done)
          begin
            len_ff <= 6'd0;
            idx_ff <= 6'd0;
            tx_len_ff <= (fc == FC_READ_HOLD) ? rd_len : 6'd6;
            state_ff <= (bcast && is_write) ? ST_RX : ST_TX;
          end
          else
            cnt_ff <= cnt_ff + 16'h0001;
        end
        ST_TX:
          if (tx_ready_i)
          begin
            idx_ff <= idx_ff + 6'd1;
            if (idx_ff == tx_len_ff - 6'd1)
              state_ff <= ST_RX;
          end
        default:
          state_ff <= ST_RX;
      endcase
    end
  end

  // ==========================================================
  // Frame capture
  always_ff @(posedge clk_i)
  begin
    if (state_ff == ST_RX && rx_i.valid && len_ff < 6'(MAX_FRAME))
      buf_ff[len_ff] <= rx_i.data;
  end

  // ==========================================================
  // Coils and holding registers
  wire logic exec_step = (state_ff == ST_EXEC) && accept && !exec_done;
  wire logic coil_wr = exec_step &&
                       (fc == FC_FORCE_ONE || fc == FC_FORCE_MANY);
  wire logic reg_wr = exec_step &&
                      (fc == FC_PRESET_ONE || fc == FC_PRESET_MANY);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      coil_ff <= '0;
    else if (coil_wr && offs < 16'(NUM_COILS))
      coil_ff[offs[6:0]] <= creg;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        reg_ff[i] <= 16'h0000;
    end
    else if (reg_wr && offs < 16'(NUM_REGS))
      reg_ff[offs[3:0]] <= preg;
  end

  // Every accepted register write is also offered to parameter storage.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      param_wr_ff <= 1'b0;
      param_num_ff <= 16'h0000;
      param_data_ff <= 16'h0000;
    end
    else
    begin
      param_wr_ff <= reg_wr;
      if (reg_wr)
      begin
        param_num_ff <= offs / 16'(PARAM_SCALE);
        param_data_ff <= preg;
      end
    end
  end

  // ==========================================================
  // Reply builder
  wire logic [5:0] rd_sel = (idx_ff - 6'd3) >> 1;
  wire logic [15:0] rd_addr = start + 16'(rd_sel);
  wire logic [15:0] rd_word = (rd_addr < 16'(NUM_REGS)) ?
                              reg_ff[rd_addr[3:0]] : 16'h0000;
  logic [7:0] tx_byte;
  always_comb
  begin
    tx_byte = buf_ff[idx_ff];
    if (fc == FC_READ_HOLD && idx_ff == 6'd2)
      tx_byte = 8'(qty << 1);
    else if (fc == FC_READ_HOLD && idx_ff > 6'd2)
      tx_byte = idx_ff[0] ? rd_word[15:8] : rd_word[7:0];
  end

  // Reply goes out only after ST_EXEC, so every write has landed first.
  wire logic tx_valid = (state_ff == ST_TX);
  wire logic tx_last = tx_valid && (idx_ff == tx_len_ff - 6'd1);
  assign tx_o = {tx_valid, tx_last, tx_byte};

  // ==========================================================
  // Drive-side outputs
  assign speed_ref_o = coil_ff[SPEED_COIL_ADDR[6:0] +: SPEED_COIL_CNT];
  assign wrctl_o = coil_ff[WRCTL_COIL_ADDR[6:0]];
  assign param_wr_o = param_wr_ff;
  assign param_nvm_o = param_wr_ff && wrctl_o;
  assign param_num_o = param_num_ff;
  assign param_data_o = param_data_ff;
  assign busy_o = (state_ff != ST_RX);

  // ==========================================================
  // Checks
  chk_badcrc_nochange: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (state_ff == ST_RX && frame_end && !rx_i.crc_ok) |=>
      state_ff == ST_RX && $stable(coil_ff))
    else $error("Bad CRC frame was taken");
  chk_bcast_silent: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (state_ff == ST_EXEC && accept && exec_done && bcast && is_write)
      |=> !tx_o.valid)
    else $error("Broadcast write answered");
  chk_coil_on: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (coil_wr && fc == FC_FORCE_ONE && qty == COIL_ON &&
     offs < 16'(NUM_COILS)) |=> coil_ff[$past(offs[6:0])])
    else $error("Coil not forced on");
  chk_reply_after: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    $rose(tx_o.valid) |-> $past(state_ff) == ST_EXEC && $past(exec_done))
    else $error("Reply before write done");
  chk_nvm_gate: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    param_nvm_o |-> param_wr_o && wrctl_o)
    else $error("NVM store without write control");
  chk_reg_write: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (reg_wr && offs < 16'(NUM_REGS)) |=> param_wr_o &&
      reg_ff[$past(offs[3:0])] == $past(preg))
    else $error("Register not written");
  chk_echo_len: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (tx_o.valid && fc != FC_READ_HOLD) |-> tx_len_ff == 6'd6)
    else $error("Write reply length wrong");
  chk_read_count: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (tx_o.valid && fc == FC_READ_HOLD && idx_ff == 6'd2)
      |-> tx_o.data == 8'(qty << 1))
    else $error("Read byte count wrong");
  chk_many_coils: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (coil_wr && fc == FC_FORCE_MANY && offs < 16'(NUM_COILS))
      |=> coil_ff[$past(offs[6:0])] == $past(creg))
    else $error("Coil range not forced");
  chk_param_num: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    reg_wr |=> param_wr_o &&
      (16'(param_num_o * 16'(PARAM_SCALE)) <= $past(offs)) &&
      ($past(offs) - 16'(param_num_o * 16'(PARAM_SCALE)) <
       16'(PARAM_SCALE)))
    else $error("Parameter number not address over ten");
  chk_tx_hold: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (tx_o.valid && !tx_ready_i) |=> tx_o.valid && $stable(tx_o.data))
    else $error("Reply byte dropped before ready");
endmodule // mbsh_handler

// ===== logic/mbsh_pkg.sv
// Constants and carrier types for the serial slave write/read handler.
// Assumes one system clock and a byte stream already deframed upstream.
package mbsh_pkg;
  // ==========================================================
  // Function codes
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_FORCE_ONE = 8'h05;
  localparam logic [7:0] FC_PRESET_ONE = 8'h06;
  localparam logic [7:0] FC_FORCE_MANY = 8'h0F;
  localparam logic [7:0] FC_PRESET_MANY = 8'h10;
  // ==========================================================
  // Field values and fixed addresses
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] WRCTL_COIL_ADDR = 16'h0040;
  localparam logic [15:0] SPEED_COIL_ADDR = 16'h0010;
  localparam int SPEED_COIL_CNT = 16;
  localparam int PARAM_SCALE = 10;
  localparam int NUM_COILS = 128;
  localparam int NUM_REGS = 16;
  localparam int MAX_FRAME = 40;
  localparam int REQ_MIN_LEN = 8;
  // ==========================================================
  // Byte stream carrier
  typedef struct packed {
    logic valid;
    logic last;
    logic crc_ok;
    logic [7:0] data;
  } mbsh_rx_s;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } mbsh_tx_s;
endpackage

// ===== testbench/mbsh_handler_tb.sv
// Self-checking bench for the request handler.
// Assumes the handler and the master model are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin logic [63:0] ca, cb; ca = 64'(a); cb = 64'(b); \
  tests_run++; if (ca !== cb) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, ca, cb); end end
module mbsh_handler_tb;
  import mbsh_pkg::*;
  logic clk_i = 0;
  logic sys_rst_i = 1;
  logic tx_ready_i, got_v, got_l, wrctl_o, param_wr_o, param_nvm_o, busy_o;
  mbsh_rx_s rx_i = '0;
  mbsh_tx_s tx_o;
  logic [15:0] speed_ref_o, param_num_o, param_data_o, v0, v1;
  logic [7:0] got_d;
  logic [7:0] fr[$];
  logic [7:0] ex[$];
  logic [8:0] rq[$];
  logic [32:0] pq[$];
  logic [32:0] pv;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  mbsh_handler mbsh_handler_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .rx_i(rx_i), .tx_o(tx_o), .tx_ready_i(tx_ready_i),
    .speed_ref_o(speed_ref_o), .wrctl_o(wrctl_o), .param_wr_o(param_wr_o),
    .param_nvm_o(param_nvm_o), .param_num_o(param_num_o),
    .param_data_o(param_data_o), .busy_o(busy_o));
  mbsh_master mbsh_master_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .tx_i(tx_o), .tx_ready_o(tx_ready_i), .got_valid_o(got_v),
    .got_last_o(got_l), .got_data_o(got_d));
  initial forever #12.5 clk_i = ~clk_i;
  // ==========================================================
  // Closing report.
  task automatic end_of_test();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Watchers of the reply stream and of parameter writes.
  always @(posedge clk_i)
  begin
    cyc++;
    if (got_v)
    begin
      if (rq.size() == 0) `CHK(got_v, 1'b0)
      else `CHK({got_l, got_d}, rq.pop_front())
    end
    if (param_wr_o)
    begin
      if (pq.size() == 0) `CHK(param_wr_o, 1'b0)
      else
      begin
        pv = {param_nvm_o, param_num_o, param_data_o};
        `CHK(pv, pq.pop_front())
      end
    end
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  // ==========================================================
  // Send one frame; rep 1 expects an echo, rep 2 the bytes in ex.
  task automatic run(input string nm, input logic ok, input int rep);
    if (rep == 1)
      ex = fr;
    if (rep != 0)
      foreach (ex[i]) rq.push_back({i == ex.size() - 1, ex[i]});
    while (busy_o !== 1'b0) @(posedge clk_i);
    foreach (fr[i])
    begin
      rx_i <= {1'b1, i == fr.size() - 1, ok, fr[i]};
      @(posedge clk_i);
    end
    rx_i <= '0;
    @(posedge clk_i);
    `CHK(busy_o, ok)
    repeat (2) @(posedge clk_i);
    while (busy_o !== 1'b0 || rq.size() != 0 || pq.size() != 0)
      @(posedge clk_i);
    $display("test %s done", nm);
  endtask
  initial
  begin
    void'($urandom(32124));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    fr = {8'h01, 8'h05, 8'h00, 8'h40, 8'hFF, 8'h00};
    run("force_one", 1'b1, 1);
    `CHK(wrctl_o, 1'b1)
    fr = {8'h01, 8'h0F, 8'h00, 8'h10, 8'h00, 8'h10, 8'h02, 8'h20, 8'h00};
    ex = {8'h01, 8'h0F, 8'h00, 8'h10, 8'h00, 8'h10};
    run("force_many", 1'b1, 2);
    `CHK(speed_ref_o, 16'h0020)
    v0 = 16'($urandom);
    v1 = 16'($urandom);
    pq.push_back({1'b1, 16'h0001, v0});
    pq.push_back({1'b1, 16'h0001, v1});
    fr = {8'h01, 8'h10, 8'h00, 8'h0A, 8'h00, 8'h02, 8'h04, v0[15:8], v0[7:0],
      v1[15:8], v1[7:0]};
    ex = {8'h01, 8'h10, 8'h00, 8'h0A, 8'h00, 8'h02};
    run("preset_many", 1'b1, 2);
    fr = {8'h01, 8'h06, 8'h00, 8'h0A, ~v0[15:8], v0[7:0]};
    run("bad_crc", 1'b0, 0);
    fr = {8'h01, 8'h03, 8'h00, 8'h0A, 8'h00, 8'h02};
    ex = {8'h01, 8'h03, 8'h04, v0[15:8], v0[7:0], v1[15:8], v1[7:0]};
    run("read_hold", 1'b1, 2);
    fr = {8'h00, 8'h05, 8'h00, 8'h40, 8'h00, 8'h00};
    run("broadcast", 1'b1, 0);
    `CHK(wrctl_o, 1'b0)
    fr = {8'h01, 8'h05, 8'h00, 8'h40, 8'h12, 8'h34};
    run("bad_value", 1'b1, 0);
    `CHK(wrctl_o, 1'b0)
    v0 = 16'($urandom);
    pq.push_back({1'b0, 16'h0000, v0});
    fr = {8'h01, 8'h06, 8'h00, 8'h01, v0[15:8], v0[7:0]};
    run("preset_one", 1'b1, 1);
    fr = {8'h01, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01};
    ex = {8'h01, 8'h03, 8'h02, v0[15:8], v0[7:0]};
    run("read_one", 1'b1, 2);
    end_of_test();
  end
endmodule // mbsh_handler_tb

// ===== testbench/mbsh_master.sv
// Bus master model that takes reply bytes from the handler.
// Assumes the reply stream uses a valid and ready handshake.
`timescale 1ns/100ps
module mbsh_master
  import mbsh_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Reply stream
  input wire mbsh_pkg::mbsh_tx_s tx_i,
  output logic tx_ready_o,
  // Bytes taken, for the bench
  output logic got_valid_o,
  output logic got_last_o,
  output logic [7:0] got_data_o
);
  // ==========================================================
  // Random stalls, so that the handler must hold each byte.
  always @(posedge clk_i)
  begin
    tx_ready_o <= !sys_rst_i && ($urandom % 3 != 0);
  end
  assign got_valid_o = tx_i.valid && tx_ready_o;
  assign got_last_o = tx_i.last;
  assign got_data_o = tx_i.data;
endmodule // mbsh_master
